/* File: verilog/srg_map.svh */
`ifndef SRG_MAP_SVH
`define SRG_MAP_SVH

// register byte addresses (chosen)
`define SRG_ADDR_CONTROL  4'h0
`define SRG_ADDR_STATUS   4'h4
`define SRG_ADDR_TXCTRL   4'h8

// control field positions
`define SRG_RESYNC_BIT    31
`define SRG_POL_BIT       30
`define SRG_SEL_BIT       29
`define SRG_FSMODE_BIT    28
`define SRG_PER_HI        27
`define SRG_PER_LO        16
`define SRG_WID_HI        15
`define SRG_WID_LO        8
`define SRG_DIV_HI        7
`define SRG_DIV_LO        0

// reset values
`define SRG_CONTROL_RESET 32'h2000_0001
`define SRG_TXCTRL_RESET  32'h0000_0000

// tx control bit positions
`define SRG_TXINT_BIT     0

// response codes
`define SRG_RESP_OKAY     2'h0
`define SRG_RESP_SLVERR   2'h2

`endif

/* File: verilog/srg_pkg.sv */
package srg_pkg;

  // decoded control register
  typedef struct packed {
    logic        resyncEn;
    logic        edgePol;
    logic        srcSel;
    logic        fsMode;
    logic [11:0] period;
    logic [7:0]  width;
    logic [7:0]  divide;
  } srg_ctrl_s;

  // generated outputs towards the serial port
  typedef struct packed {
    logic bitClk;
    logic frameSync;
  } srg_gen_s;

  // bus write handshake state
  typedef enum logic [1:0] {
    SRG_WR_IDLE = 2'b00,
    SRG_WR_RESP = 2'b01
  } srg_wr_e;

endpackage

/* File: verilog/srg_frame_timer.sv */
`timescale 1ns/10ps
`include "srg_map.svh"

// frame counter on the generated clock time base
module srg_frame_timer
  import srg_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // time base
  input  wire logic        bitTick,
  input  wire logic        resyncHit,
  input  wire logic        resyncMode,
  // settings
  input  wire logic [11:0] period,
  input  wire logic [7:0]  width,
  // result
  output logic             frameSync
);

  logic [11:0] count;
  logic [11:0] next_count;
  logic [8:0]  widthLeft;
  logic [8:0]  next_widthLeft;
  logic        next_frameSync;

  // next frame counter and pulse width
  always_comb begin
    next_count     = count;
    next_widthLeft = widthLeft;
    next_frameSync = frameSync;
    if (resyncMode) begin
      // RULE4 pulse only on receive sync
      if (resyncHit) begin
        next_widthLeft = {1'b0, width} + 9'h001;
        next_count     = 12'h000;
      end
    end else if (bitTick) begin
      // RULE7 period plus one spacing
      if (count >= period) begin
        next_count     = 12'h000;
        next_widthLeft = {1'b0, width} + 9'h001;
      end else begin
        next_count = count + 12'h001;
      end
    end
    // RULE11 width counted in bit clocks
    if (bitTick && widthLeft != 9'h000 && !(resyncMode && resyncHit) && !(!resyncMode && count >= period)) begin
      next_widthLeft = widthLeft - 9'h001;
    end
    // RULE8 width plus one active
    next_frameSync = (next_widthLeft != 9'h000);
  end

  // registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count     <= 12'h000;
      widthLeft <= 9'h000;
      frameSync <= 1'b0;
    end else begin
      count     <= next_count;
      widthLeft <= next_widthLeft;
      frameSync <= next_frameSync;
    end
  end

endmodule

/* File: verilog/srg_sample_rate_gen.sv */
// Behaviour
// RULE1: mode bit selects pin or CPU clock
// RULE2: polarity bit picks pin active edge
// RULE3: resync clear means free running clock
// RULE4: resync set: align, pulse on receive sync (done with pin source only, ignored with CPU clock)
// RULE5: mode 0: sync on each transmit copy
// RULE6: mode 1: sync from generated frame sync
// RULE7: frame spacing is period field plus one
// RULE8: pulse width is width field plus one
// RULE9: divider field sets generated clock divide
// RULE10: generated rate is source over divider+1 (bit clock is source over 2 when divider is 0)
// RULE11: width counted in generated clock periods
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "srg_map.svh"

module srg_sample_rate_gen
  import srg_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // axi4-lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins from the link
  input  wire logic        externalSourceClock,
  input  wire logic        receiveFrameSync,
  // serial port side
  input  wire logic        txCopyPulse,
  output logic             generatedBitClock,
  output logic             generatedFrameSync,
  output logic             transmitFrameSync
);

  // register state
  logic [31:0] ctrlReg;
  logic [31:0] next_ctrlReg;
  logic [31:0] txCtrlReg;
  logic [31:0] next_txCtrlReg;
  srg_ctrl_s   ctrl;

  // bus state
  logic        awHeld;
  logic        next_awHeld;
  logic [3:0]  awAddr;
  logic [3:0]  next_awAddr;
  logic        wHeld;
  logic        next_wHeld;
  logic [31:0] wData;
  logic [31:0] next_wData;
  logic [3:0]  wStrb;
  logic [3:0]  next_wStrb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  // pin synchronisers
  logic [2:0]  clkPinSync;
  logic [2:0]  fsPinSync;

  // divider state
  logic [7:0]  divCount;
  logic [7:0]  next_divCount;
  logic        bitClk;
  logic        next_bitClk;
  logic        bitTick;
  logic        srcTick;
  logic        resyncHit;
  logic        resyncMode;
  logic        frameSyncRaw;
  logic        next_genClkOut;
  logic        next_genFsOut;
  logic        next_txFsOut;

  assign ctrl = srg_ctrl_s'(ctrlReg);

  // merge byte lanes into a word
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal, input logic [31:0] newVal,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // address is one of the mapped words
  function automatic logic addrMapped(input logic [3:0] addr);
    return (addr == `SRG_ADDR_CONTROL) || (addr == `SRG_ADDR_STATUS) || (addr == `SRG_ADDR_TXCTRL);
  endfunction

  // two flops on the pins before use, third for edges
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      clkPinSync <= 3'h0;
      fsPinSync  <= 3'h0;
    end else begin
      clkPinSync <= {clkPinSync[1:0], externalSourceClock};
      fsPinSync  <= {fsPinSync[1:0], receiveFrameSync};
    end
  end

  // source tick selection
  always_comb begin
    // RULE1 pin or cpu clock
    if (ctrl.srcSel) begin
      srcTick = 1'b1;
    end else begin
      // RULE2 pin edge polarity
      srcTick = ctrl.edgePol ? (clkPinSync[2] & ~clkPinSync[1]) : (~clkPinSync[2] & clkPinSync[1]);
    end
    // RULE3 resync only with pin source
    resyncMode = ctrl.resyncEn && !ctrl.srcSel;
    resyncHit  = resyncMode && fsPinSync[1] && !fsPinSync[2];
  end

  // divider next state
  always_comb begin
    next_divCount = divCount;
    next_bitClk   = bitClk;
    bitTick       = 1'b0;
    if (resyncMode && resyncHit) begin
      // RULE4 realign generated clock
      next_divCount = 8'h00;
      next_bitClk   = 1'b1;
      bitTick       = 1'b1;
    end else if (srcTick) begin
      // RULE9 RULE10 divide by value plus one
      if (divCount >= ctrl.divide) begin
        next_divCount = 8'h00;
        bitTick       = 1'b1;
        next_bitClk   = 1'b1;
      end else begin
        next_divCount = divCount + 8'h01;
        if (divCount + 8'h01 > (ctrl.divide >> 1)) begin
          next_bitClk = 1'b0;
        end
      end
      if (ctrl.divide == 8'h00) begin
        next_bitClk = ~bitClk;
      end
    end
  end

  // divider registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      divCount <= 8'h00;
      bitClk   <= 1'b0;
    end else begin
      divCount <= next_divCount;
      bitClk   <= next_bitClk;
    end
  end

  // frame timing
  srg_frame_timer frameTimer (
    .clock      (clock),
    .rst_b      (rst_b),
    .bitTick    (bitTick),
    .resyncHit  (resyncHit),
    .resyncMode (resyncMode),
    .period     (ctrl.period),
    .width      (ctrl.width),
    .frameSync  (frameSyncRaw)
  );

  // output selection
  always_comb begin
    next_genClkOut = bitClk;
    next_genFsOut  = frameSyncRaw;
    next_txFsOut   = 1'b0;
    if (txCtrlReg[`SRG_TXINT_BIT]) begin
      // RULE5 RULE6 transmit sync source
      next_txFsOut = ctrl.fsMode ? frameSyncRaw : txCopyPulse;
    end
  end

  // output registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      generatedBitClock  <= 1'b0;
      generatedFrameSync <= 1'b0;
      transmitFrameSync  <= 1'b0;
    end else begin
      generatedBitClock  <= next_genClkOut;
      generatedFrameSync <= next_genFsOut;
      transmitFrameSync  <= next_txFsOut;
    end
  end

  // bus next state
  always_comb begin
    next_awHeld    = awHeld;
    next_awAddr    = awAddr;
    next_wHeld     = wHeld;
    next_wData     = wData;
    next_wStrb     = wStrb;
    next_bvalid    = s_axi_bvalid;
    next_bresp     = s_axi_bresp;
    next_rvalid    = s_axi_rvalid;
    next_rdata     = s_axi_rdata;
    next_rresp     = s_axi_rresp;
    next_ctrlReg   = ctrlReg;
    next_txCtrlReg = txCtrlReg;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    // perform write once both halves held
    if (awHeld && wHeld && !s_axi_bvalid) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = addrMapped(awAddr) ? `SRG_RESP_OKAY : `SRG_RESP_SLVERR;
      if (awAddr == `SRG_ADDR_CONTROL) begin
        next_ctrlReg = mergeBytes(ctrlReg, wData, wStrb);
      end
      if (awAddr == `SRG_ADDR_TXCTRL) begin
        next_txCtrlReg = mergeBytes(txCtrlReg, wData, wStrb) & 32'h0000_0001;
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // read path
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = addrMapped(s_axi_araddr) ? `SRG_RESP_OKAY : `SRG_RESP_SLVERR;
      case (s_axi_araddr)
        `SRG_ADDR_CONTROL: next_rdata = ctrlReg;
        `SRG_ADDR_STATUS:  next_rdata = {29'h0, frameSyncRaw, bitClk, resyncMode};
        `SRG_ADDR_TXCTRL:  next_rdata = txCtrlReg;
        default:           next_rdata = 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // bus registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awHeld        <= 1'b0;
      awAddr        <= 4'h0;
      wHeld         <= 1'b0;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
      ctrlReg       <= `SRG_CONTROL_RESET;
      txCtrlReg     <= `SRG_TXCTRL_RESET;
    end else begin
      awHeld        <= next_awHeld;
      awAddr        <= next_awAddr;
      wHeld         <= next_wHeld;
      wData         <= next_wData;
      wStrb         <= next_wStrb;
      s_axi_awready <= !next_awHeld && !next_bvalid;
      s_axi_wready  <= !next_wHeld && !next_bvalid;
      s_axi_arready <= !next_rvalid;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      ctrlReg       <= next_ctrlReg;
      txCtrlReg     <= next_txCtrlReg;
    end
  end

endmodule

/* File: dv/srg_sample_rate_gen_properties.sv */
`timescale 1ns/10ps
`include "srg_map.svh"

module srg_sample_rate_gen_props
  import srg_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // bus
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  // link
  input wire logic        receiveFrameSync,
  input wire logic        txCopyPulse,
  input wire logic        generatedBitClock,
  input wire logic        generatedFrameSync,
  input wire logic        transmitFrameSync
);
  srg_ctrl_s   ctl;
  logic        txInt;
  logic        wrHit;
  logic        settled;
  logic [15:0] quiet;
  logic [15:0] hiCnt;
  logic [15:0] riseCnt;
  logic [15:0] bitCnt;
  logic [15:0] frameLen;

  // settled once a few frames passed since the last write, with cpu source and resync clear
  assign wrHit    = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign frameLen = 16'((ctl.period + 1) * (ctl.divide + 1));
  assign settled  = ctl.srcSel && !ctl.resyncEn && (quiet > 3 * frameLen + 40);

  // register shadow and cycle counters
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctl     <= srg_ctrl_s'(`SRG_CONTROL_RESET);
      txInt   <= 1'b0;
      quiet   <= 16'h0000;
      hiCnt   <= 16'h0000;
      riseCnt <= 16'h0000;
      bitCnt  <= 16'h0000;
    end else begin
      if (wrHit && s_axi_awaddr == `SRG_ADDR_CONTROL) begin
        ctl <= srg_ctrl_s'(s_axi_wdata);
      end
      if (wrHit && s_axi_awaddr == `SRG_ADDR_TXCTRL) begin
        txInt <= s_axi_wdata[`SRG_TXINT_BIT];
      end
      quiet   <= wrHit ? 16'h0000 : quiet + {15'h0000, quiet != 16'hffff};
      hiCnt   <= generatedFrameSync ? hiCnt + 16'h0001 : 16'h0000;
      riseCnt <= $rose(generatedFrameSync) ? 16'h0001 : riseCnt + 16'h0001;
      bitCnt  <= $rose(generatedBitClock) ? 16'h0001 : bitCnt + 16'h0001;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
  property p_wresp; wrHit |-> !s_axi_bvalid ##2 s_axi_bvalid; endproperty
  a_wresp: assert property (p_wresp) else $error("write answer late");
  property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rresp: assert property (p_rresp) else $error("read answer late");
  property p_period; $rose(generatedFrameSync) && settled |-> riseCnt == frameLen; endproperty
  a_period: assert property (p_period) else $error("frame spacing wrong");
  property p_width;
    $fell(generatedFrameSync) && settled |-> hiCnt == 16'((ctl.width + 1) * (ctl.divide + 1));
  endproperty
  a_width: assert property (p_width) else $error("frame width wrong");
  property p_rate; $rose(generatedBitClock) && settled && ctl.divide != 8'h00 |-> bitCnt == ctl.divide + 1; endproperty
  a_rate: assert property (p_rate) else $error("bit clock rate wrong");
  property p_copy; quiet > 8 && txInt && !ctl.fsMode |=> transmitFrameSync == $past(txCopyPulse); endproperty
  a_copy: assert property (p_copy) else $error("no sync on copy");
  property p_gen; quiet > 8 && txInt && ctl.fsMode && $rose(generatedFrameSync) |-> ##[0:2] transmitFrameSync; endproperty
  a_gen: assert property (p_gen) else $error("sync not following frame");
  property p_resync; quiet > 8 && ctl.resyncEn && !ctl.srcSel && $rose(receiveFrameSync) |-> ##[1:40] generatedFrameSync;
  endproperty
  a_resync: assert property (p_resync) else $error("no frame after receive sync");

  // main scenarios
  c_tx: cover property ($rose(transmitFrameSync));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == `SRG_RESP_SLVERR);
  c_frame: cover property ($fell(generatedFrameSync) && settled);
endmodule

bind srg_sample_rate_gen srg_sample_rate_gen_props i_props (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .receiveFrameSync, .txCopyPulse, .generatedBitClock,
  .generatedFrameSync, .transmitFrameSync);

/* File: dv/srg_port_model.sv */
`timescale 1ns/10ps

module srg_port_model
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // traffic enables
  input  wire logic clkEn,
  input  wire logic rxEn,
  input  wire logic txEn,
  // pins towards the generator
  output logic      externalSourceClock,
  output logic      receiveFrameSync,
  output logic      txCopyPulse
);
  logic [5:0] slot;

  // pin clock unrelated in phase, still when idle
  initial externalSourceClock = 1'b0;
  always #23 externalSourceClock = clkEn ? ~externalSourceClock : 1'b0;

  // receive sync every 64 cycles, copy every 16
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      slot             <= 6'h00;
      receiveFrameSync <= 1'b0;
      txCopyPulse      <= 1'b0;
    end else begin
      slot             <= slot + 6'h01;
      receiveFrameSync <= rxEn && slot < 6'h04;
      txCopyPulse      <= txEn && slot[3:0] == 4'hf;
    end
  end
endmodule

/* File: dv/srg_sample_rate_gen_tb_top.sv */
`timescale 1ns/10ps
`include "srg_map.svh"

module srg_sample_rate_gen_tb_top
  import srg_pkg::*;
;
  logic        clock, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, clkEn, rxEn, txEn;
  logic        externalSourceClock, receiveFrameSync, txCopyPulse;
  logic        generatedBitClock, generatedFrameSync, transmitFrameSync;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp, mon;
  int          errors, n_checks, t0, t1;
  srg_ctrl_s   c;

  assign mon = {generatedFrameSync, transmitFrameSync};

  srg_sample_rate_gen i_srg_sample_rate_gen (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .externalSourceClock, .receiveFrameSync, .txCopyPulse, .generatedBitClock, .generatedFrameSync,
    .transmitFrameSync);
  srg_port_model i_srg_port_model (.clock, .rst_b, .clkEn, .rxEn, .txEn, .externalSourceClock,
    .receiveFrameSync, .txCopyPulse);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge clock);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // wait up to 400 cycles for one monitored output to be high
  task automatic seen(input int b);
    for (int k = 0; k < 400 && !mon[b]; k++) @(posedge clock);
    chk({31'h0, mon[b]}, 32'h1);
  endtask

  task results;
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    results();
  end

  initial begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, clkEn, rxEn, txEn} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    // reset values, unmapped place
    rd(`SRG_ADDR_CONTROL);
    chk(rdat, `SRG_CONTROL_RESET);
    rd(`SRG_ADDR_TXCTRL);
    chk(rdat, `SRG_TXCTRL_RESET);
    rd(4'hc);
    chk(rdat, 32'h0000_0000);
    chk({30'h0, resp}, {30'h0, `SRG_RESP_SLVERR});
    wr(4'hc, 32'h1);
    chk({30'h0, resp}, {30'h0, `SRG_RESP_SLVERR});
    // cpu source: divide, period and width corners
    for (int i = 0; i < 3; i++) begin
      c = '{1'b0, 1'b0, 1'b1, 1'b0, 12'(3 + i), 8'(i), 8'((i + 1) % 3)};
      wr(`SRG_ADDR_CONTROL, c);
      rd(`SRG_ADDR_CONTROL);
      chk(rdat, c);
      repeat (60) @(posedge clock);
      @(posedge generatedFrameSync) t0 = $time;
      @(negedge generatedFrameSync) t1 = $time;
      chk((t1 - t0) / 10, (i + 1) * ((i + 1) % 3 + 1));
      @(posedge generatedFrameSync) t1 = $time;
      chk((t1 - t0) / 10, (i + 4) * ((i + 1) % 3 + 1));
    end
    // transmit sync: copy mode then generated mode
    txEn <= 1'b1;
    wr(`SRG_ADDR_TXCTRL, 32'h1);
    seen(0);
    txEn <= 1'b0;
    c.fsMode = 1'b1;
    wr(`SRG_ADDR_CONTROL, c);
    repeat (20) @(posedge clock);
    seen(0);
    // pin source with resync, both edges
    clkEn <= 1'b1;
    rxEn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      // active pin edge to bit clock toggle takes three to four cycles
      wr(`SRG_ADDR_CONTROL, {1'b0, 1'(p), 30'h0});
      repeat (20) @(posedge clock);
      if (p == 0) @(posedge externalSourceClock);
      else @(negedge externalSourceClock);
      t0 = $time;
      @(generatedBitClock) t1 = $time;
      chk(32'(t1 - t0 >= 30 && t1 - t0 <= 40), 32'h1);
      wr(`SRG_ADDR_CONTROL, {1'b1, 1'(p), 2'b00, 12'hfff, 16'h0000});
      repeat (100) @(posedge clock);
      seen(1);
    end
    results();
  end
endmodule
